// ==== design/piwc_defs.vh ====
// Constants for the pin interrupt and wake-up controller
`ifndef PIWC_DEFS_VH
`define PIWC_DEFS_VH
`define PIWC_ADDR_W 8
`define PIWC_OFS_POWER_CONTROL 8'h87
`define PIWC_OFS_TPC 8'h88
`define PIWC_OFS_IFR 8'h95
`define PIWC_OFS_IEN 8'ha0
`define PIWC_OFS_P1WK 8'ha4
`define PIWC_OFS_IRQST 8'ha8
`define PIWC_OFS_IRQMSK 8'hac
`define PIWC_BIT_IDL 0
`define PIWC_BIT_STOP 1
`define PIWC_BIT_IT0 0
`define PIWC_BIT_IE0 1
`define PIWC_BIT_IT1 2
`define PIWC_BIT_IE1 3
`define PIWC_BIT_IE2 2
`define PIWC_BIT_P1F 1
`define PIWC_IFR_CLR2 8'hfb
`define PIWC_IFR_MASK 8'h06
`define PIWC_TPC_MASK 8'h0f
`define PIWC_POWER_CONTROL_MASK 8'h8f
`define PIWC_WARMUP_NS 1000
`define PIWC_CLK_MHZ 10
`endif

// ==== design/piwc_edge.v ====
// Falling-edge and change detector for one group of pins
module piwc_edge #(
    parameter W = 1
) (
    clk,
    rst,
    pin,
    fall,
    chg
);
    input clk;
    input rst;
    input [W-1:0] pin;
    output [W-1:0] fall;
    output [W-1:0] chg;
    wire clk;
    wire rst;
    wire [W-1:0] pin;
    reg [W-1:0] prev_r;
    reg valid_r;
    // No edge is reported until one real sample follows reset, so a pin
    // whose idle level differs from the reset value gives no false edge
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            prev_r <= {W{1'b1}};
            valid_r <= 1'b0;
        end else begin
            prev_r <= pin;
            valid_r <= 1'b1;
        end
    end
    assign fall = {W{valid_r}} & prev_r & ~pin;
    assign chg = {W{valid_r}} & (prev_r ^ pin);
endmodule // piwc_edge

// ==== design/piwc_axil.v ====
// AXI4-Lite slave front end: one write and one read at a time
module piwc_axil (
    clk,
    rst,
    awaddr,
    awvalid,
    awready,
    wdata,
    wstrb,
    wvalid,
    wready,
    bresp,
    bvalid,
    bready,
    araddr,
    arvalid,
    arready,
    rdata,
    rresp,
    rvalid,
    rready,
    wr_en,
    wr_addr,
    wr_data,
    wr_ok,
    rd_addr,
    rd_data,
    rd_ok
);
    input clk;
    input rst;
    input [31:0] awaddr;
    input awvalid;
    output awready;
    input [31:0] wdata;
    input [3:0] wstrb;
    input wvalid;
    output wready;
    output [1:0] bresp;
    output bvalid;
    input bready;
    input [31:0] araddr;
    input arvalid;
    output arready;
    output [31:0] rdata;
    output [1:0] rresp;
    output rvalid;
    input rready;
    output wr_en;
    output [7:0] wr_addr;
    output [7:0] wr_data;
    input wr_ok;
    output [7:0] rd_addr;
    input [7:0] rd_data;
    input rd_ok;
    wire clk, rst, awvalid, wvalid, bready, arvalid, rready, wr_ok, rd_ok;
    wire [31:0] awaddr, wdata, araddr;
    wire [3:0] wstrb;
    wire [7:0] rd_data;
    reg aw_r, w_r, bvalid_r, rvalid_r, bad_r, rbad_r;
    reg [7:0] awa_r, wd_r, ra_r;
    reg [31:0] rdata_r;
    assign awready = ~aw_r & ~bvalid_r;
    assign wready = ~w_r & ~bvalid_r;
    assign arready = ~rvalid_r;
    assign bvalid = bvalid_r;
    assign rvalid = rvalid_r;
    assign bresp = bad_r ? 2'h2 : 2'h0;
    assign rresp = rbad_r ? 2'h2 : 2'h0;
    assign rdata = rdata_r;
    assign wr_addr = awa_r;
    assign wr_data = wd_r;
    assign rd_addr = araddr[9:2];
    // Write fires once both halves are held; lane 0 carries the byte
    assign wr_en = aw_r & w_r & ~bvalid_r;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            aw_r <= 1'b0;
            w_r <= 1'b0;
            bvalid_r <= 1'b0;
            bad_r <= 1'b0;
            awa_r <= 8'h00;
            wd_r <= 8'h00;
            rvalid_r <= 1'b0;
            rbad_r <= 1'b0;
            ra_r <= 8'h00;
            rdata_r <= 32'h00000000;
        end else begin
            if (awvalid && awready) begin
                aw_r <= 1'b1;
                awa_r <= awaddr[9:2];
            end
            if (wvalid && wready) begin
                w_r <= 1'b1;
                wd_r <= wstrb[0] ? wdata[7:0] : 8'h00;
            end
            if (wr_en) begin
                aw_r <= 1'b0;
                w_r <= 1'b0;
                bvalid_r <= 1'b1;
                bad_r <= ~wr_ok;
            end else if (bvalid_r && bready) begin
                bvalid_r <= 1'b0;
            end
            if (arvalid && arready) begin
                rvalid_r <= 1'b1;
                rbad_r <= ~rd_ok;
                rdata_r <= {24'h000000, rd_ok ? rd_data : 8'h00};
            end else if (rvalid_r && rready) begin
                rvalid_r <= 1'b0;
            end
        end
    end
endmodule // piwc_axil

// ==== design/piwc_top.v ====
// Pin interrupt, Idle and Stop wake-up controller
`include "piwc_defs.vh"
module piwc_top #(
    parameter WARMUP_CYC = (`PIWC_WARMUP_NS * `PIWC_CLK_MHZ + 999) / 1000
) (
    CORE_CLK,
    RST,
    S_AXI_AWADDR,
    S_AXI_AWVALID,
    S_AXI_AWREADY,
    S_AXI_WDATA,
    S_AXI_WSTRB,
    S_AXI_WVALID,
    S_AXI_WREADY,
    S_AXI_BRESP,
    S_AXI_BVALID,
    S_AXI_BREADY,
    S_AXI_ARADDR,
    S_AXI_ARVALID,
    S_AXI_ARREADY,
    S_AXI_RDATA,
    S_AXI_RRESP,
    S_AXI_RVALID,
    S_AXI_RREADY,
    EXT_IRQ_PIN0,
    EXT_IRQ_PIN1,
    EXT_IRQ_PIN2,
    PORT1_PIN,
    OTHER_IRQ_REQ,
    OTHER_IRQ_EN,
    GLOBAL_IRQ_ENABLE,
    IRQ_ACK,
    IRQ_REQ,
    CLK_RUN,
    CPU_RUN,
    IDLE_MODE,
    STOP_MODE,
    IRQ
);
    input CORE_CLK;
    input RST;
    input [31:0] S_AXI_AWADDR;
    input S_AXI_AWVALID;
    output S_AXI_AWREADY;
    input [31:0] S_AXI_WDATA;
    input [3:0] S_AXI_WSTRB;
    input S_AXI_WVALID;
    output S_AXI_WREADY;
    output [1:0] S_AXI_BRESP;
    output S_AXI_BVALID;
    input S_AXI_BREADY;
    input [31:0] S_AXI_ARADDR;
    input S_AXI_ARVALID;
    output S_AXI_ARREADY;
    output [31:0] S_AXI_RDATA;
    output [1:0] S_AXI_RRESP;
    output S_AXI_RVALID;
    input S_AXI_RREADY;
    input EXT_IRQ_PIN0;
    input EXT_IRQ_PIN1;
    input EXT_IRQ_PIN2;
    input [7:0] PORT1_PIN;
    input [4:0] OTHER_IRQ_REQ;
    input [4:0] OTHER_IRQ_EN;
    input GLOBAL_IRQ_ENABLE;
    input [3:0] IRQ_ACK;
    output [3:0] IRQ_REQ;
    output CLK_RUN;
    output CPU_RUN;
    output IDLE_MODE;
    output STOP_MODE;
    output IRQ;
    wire CORE_CLK, RST, EXT_IRQ_PIN0, EXT_IRQ_PIN1, EXT_IRQ_PIN2;
    wire GLOBAL_IRQ_ENABLE;
    wire [7:0] PORT1_PIN;
    wire [4:0] OTHER_IRQ_REQ, OTHER_IRQ_EN;
    wire [3:0] IRQ_ACK;

    localparam ST_RUN = 4'h1;
    localparam ST_IDLE = 4'h2;
    localparam ST_STOP = 4'h4;
    localparam ST_WARM = 4'h8;
    localparam WARM_W = 16;

    reg [3:0] state_r, state_nxt;
    reg [7:0] power_control_r;
    reg [3:0] tpc_r;
    reg ie0_r, ie1_r, ie2_r, p1f_r;
    reg [3:0] ien_r;
    reg [7:0] p1wk_r;
    reg [3:0] irqst_r, irqmsk_r;
    reg [WARM_W-1:0] warm_r;
    reg p1_wake_r;
    reg [3:0] req_r;

    wire [2:0] ext_pins;
    wire [2:0] ext_fall;
    wire [7:0] p1_chg;
    wire wr_en, wr_ok, rd_ok;
    wire [7:0] wr_addr, wr_data, rd_addr;
    reg [7:0] rd_data;

    wire pin0_irq_enable = ien_r[0];
    wire pin1_irq_enable = ien_r[1];
    wire pin2_irq_enable = ien_r[2];
    wire port1_change_irq_enable = ien_r[3];
    wire sampling = (state_r == ST_RUN) || (state_r == ST_IDLE);

    assign ext_pins = {EXT_IRQ_PIN2, EXT_IRQ_PIN1, EXT_IRQ_PIN0};

    piwc_edge #(.W(3)) u_ext (
        .clk(CORE_CLK),
        .rst(RST),
        .pin(ext_pins),
        .fall(ext_fall),
        .chg()
    );

    piwc_edge #(.W(8)) u_p1 (
        .clk(CORE_CLK),
        .rst(RST),
        .pin(PORT1_PIN),
        .fall(),
        .chg(p1_chg)
    );

    piwc_axil u_bus (
        .clk(CORE_CLK),
        .rst(RST),
        .awaddr(S_AXI_AWADDR),
        .awvalid(S_AXI_AWVALID),
        .awready(S_AXI_AWREADY),
        .wdata(S_AXI_WDATA),
        .wstrb(S_AXI_WSTRB),
        .wvalid(S_AXI_WVALID),
        .wready(S_AXI_WREADY),
        .bresp(S_AXI_BRESP),
        .bvalid(S_AXI_BVALID),
        .bready(S_AXI_BREADY),
        .araddr(S_AXI_ARADDR),
        .arvalid(S_AXI_ARVALID),
        .arready(S_AXI_ARREADY),
        .rdata(S_AXI_RDATA),
        .rresp(S_AXI_RRESP),
        .rvalid(S_AXI_RVALID),
        .rready(S_AXI_RREADY),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_ok(wr_ok),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_ok(rd_ok)
    );

    // Word index of each register, as seen by the bus front end
    function is_reg;
        input [7:0] idx;
        input [7:0] ofs;
        begin
            is_reg = (idx == ofs);
        end
    endfunction

    function known;
        input [7:0] idx;
        begin
            known = is_reg(idx, `PIWC_OFS_POWER_CONTROL) | is_reg(idx, `PIWC_OFS_TPC)
                | is_reg(idx, `PIWC_OFS_IFR) | is_reg(idx, `PIWC_OFS_IEN)
                | is_reg(idx, `PIWC_OFS_P1WK) | is_reg(idx, `PIWC_OFS_IRQST)
                | is_reg(idx, `PIWC_OFS_IRQMSK);
        end
    endfunction

    assign wr_ok = known(wr_addr);
    assign rd_ok = known(rd_addr);

    wire wr_power_control = wr_en & is_reg(wr_addr, `PIWC_OFS_POWER_CONTROL);
    wire wr_tpc = wr_en & is_reg(wr_addr, `PIWC_OFS_TPC);
    wire wr_ifr = wr_en & is_reg(wr_addr, `PIWC_OFS_IFR);
    wire wr_ien = wr_en & is_reg(wr_addr, `PIWC_OFS_IEN);
    wire wr_p1wk = wr_en & is_reg(wr_addr, `PIWC_OFS_P1WK);
    wire wr_st = wr_en & is_reg(wr_addr, `PIWC_OFS_IRQST);
    wire wr_msk = wr_en & is_reg(wr_addr, `PIWC_OFS_IRQMSK);

    // Pin held low with its wake-up enabled blocks Stop entry
    wire stop_block = |(~ext_pins & ien_r[2:0]);
    wire stop_go = wr_power_control & wr_data[`PIWC_BIT_STOP] & ~stop_block;
    wire idle_go = wr_power_control & wr_data[`PIWC_BIT_IDL] & ~stop_go;

    // Requests while clocked; level mode follows the pin directly
    wire lvl0 = ~tpc_r[`PIWC_BIT_IT0] & ~EXT_IRQ_PIN0;
    wire lvl1 = ~tpc_r[`PIWC_BIT_IT1] & ~EXT_IRQ_PIN1;
    wire src0 = tpc_r[`PIWC_BIT_IT0] ? ie0_r : lvl0;
    wire src1 = tpc_r[`PIWC_BIT_IT1] ? ie1_r : lvl1;
    wire [3:0] pend = {p1f_r, ie2_r, src1, src0};
    wire [3:0] pend_en = pend & {port1_change_irq_enable, pin2_irq_enable,
        pin1_irq_enable, pin0_irq_enable};
    wire other_en = |(OTHER_IRQ_REQ & OTHER_IRQ_EN);
    // Idle wakes only through globally enabled sources
    wire idle_wake = GLOBAL_IRQ_ENABLE & ((|pend_en) | other_en);
    // Stop wake is asynchronous to sampling; pin enables alone suffice
    wire stop_wake = (|(~ext_pins & ien_r[2:0]))
        | (|(p1_chg & p1wk_r));

    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_RUN: begin
                if (stop_go) begin
                    state_nxt = ST_STOP;
                end else if (idle_go) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (idle_wake) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_STOP: begin
                if (stop_wake) begin
                    state_nxt = ST_WARM;
                end
            end
            ST_WARM: begin
                if (warm_r == WARMUP_CYC[WARM_W-1:0] - 16'h0001) begin
                    state_nxt = ST_RUN;
                end
            end
            default: begin
                state_nxt = ST_RUN;
            end
        endcase
    end

    always @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            state_r <= ST_RUN;
            warm_r <= 16'h0000;
        end else begin
            state_r <= state_nxt;
            if (state_r == ST_WARM) begin
                warm_r <= warm_r + 16'h0001;
            end else begin
                warm_r <= 16'h0000;
            end
        end
    end

    // Edge flags: set wins over both handler-entry and software clears
    always @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            ie0_r <= 1'b0;
            ie1_r <= 1'b0;
            ie2_r <= 1'b0;
            p1f_r <= 1'b0;
            p1_wake_r <= 1'b0;
        end else begin
            // External pin edges count only in Run and Idle, not during warm-up, so pins can settle first
            if (sampling && ext_fall[0]) begin
                ie0_r <= 1'b1;
            end else if (IRQ_ACK[0] ||
                (wr_tpc && !wr_data[`PIWC_BIT_IE0])) begin
                ie0_r <= 1'b0;
            end
            if (sampling && ext_fall[1]) begin
                ie1_r <= 1'b1;
            end else if (IRQ_ACK[1] ||
                (wr_tpc && !wr_data[`PIWC_BIT_IE1])) begin
                ie1_r <= 1'b0;
            end
            if (sampling && ext_fall[2]) begin
                ie2_r <= 1'b1;
            end else if (IRQ_ACK[2] || (wr_ifr && !wr_data[`PIWC_BIT_IE2])) begin
                ie2_r <= 1'b0;
            end
            // A Port1 change on a pin enabled in P1WK latches even while the clock is stopped
            p1_wake_r <= (state_r == ST_STOP) && (|(p1_chg & p1wk_r));
            if ((sampling && (|p1_chg)) || p1_wake_r) begin
                p1f_r <= 1'b1;
            end else if (IRQ_ACK[3] || (wr_ifr && !wr_data[`PIWC_BIT_P1F])) begin
                p1f_r <= 1'b0;
            end
        end
    end

    // Registered requests to the core are off from the second Stop cycle and during warm-up
    always @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            req_r <= 4'h0;
        end else begin
            req_r <= (sampling && GLOBAL_IRQ_ENABLE) ? pend_en : 4'h0;
        end
    end

    always @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            power_control_r <= 8'h00;
            tpc_r <= 4'h0;
            ien_r <= 4'h0;
            p1wk_r <= 8'h00;
            irqmsk_r <= 4'h0;
            irqst_r <= 4'h0;
        end else begin
            if (wr_power_control) begin
                power_control_r <= wr_data & `PIWC_POWER_CONTROL_MASK & 8'hfc;
            end
            if (wr_tpc) begin
                tpc_r <= {1'b0, wr_data[`PIWC_BIT_IT1], 1'b0,
                    wr_data[`PIWC_BIT_IT0]};
            end
            if (wr_ien) begin
                ien_r <= wr_data[3:0];
            end
            if (wr_p1wk) begin
                p1wk_r <= wr_data;
            end
            if (wr_msk) begin
                irqmsk_r <= wr_data[3:0];
            end
            irqst_r <= (irqst_r & ~(wr_st ? wr_data[3:0] : 4'h0))
                | {p1f_r, ie2_r, ie1_r, ie0_r};
        end
    end

    always @* begin
        rd_data = 8'h00;
        if (is_reg(rd_addr, `PIWC_OFS_POWER_CONTROL)) begin
            rd_data = power_control_r | {6'h00, state_r == ST_STOP, state_r == ST_IDLE};
        end else if (is_reg(rd_addr, `PIWC_OFS_TPC)) begin
            rd_data = {4'h0, ie1_r, tpc_r[2], ie0_r, tpc_r[0]};
        end else if (is_reg(rd_addr, `PIWC_OFS_IFR)) begin
            rd_data = {5'h00, ie2_r, p1f_r, 1'b0};
        end else if (is_reg(rd_addr, `PIWC_OFS_IEN)) begin
            rd_data = {4'h0, ien_r};
        end else if (is_reg(rd_addr, `PIWC_OFS_P1WK)) begin
            rd_data = p1wk_r;
        end else if (is_reg(rd_addr, `PIWC_OFS_IRQST)) begin
            rd_data = {4'h0, irqst_r};
        end else if (is_reg(rd_addr, `PIWC_OFS_IRQMSK)) begin
            rd_data = {4'h0, irqmsk_r};
        end
    end

    assign IRQ_REQ = req_r;
    assign CLK_RUN = (state_r != ST_STOP);
    assign CPU_RUN = (state_r == ST_RUN);
    assign IDLE_MODE = (state_r == ST_IDLE);
    assign STOP_MODE = (state_r == ST_STOP) || (state_r == ST_WARM);
    assign IRQ = |(irqst_r & irqmsk_r);
endmodule // piwc_top

// ==== tb/piwc_props.sv ====
// Concurrent checks on the controller's top-level ports
module piwc_props #(
    parameter WARMUP_CYC = 10
) (
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic EXT_IRQ_PIN2,
    input wire logic GLOBAL_IRQ_ENABLE,
    input wire logic [3:0] IRQ_ACK,
    input wire logic [3:0] IRQ_REQ,
    input wire logic CLK_RUN,
    input wire logic CPU_RUN,
    input wire logic IDLE_MODE,
    input wire logic STOP_MODE
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] wu_cnt_r;
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    // Length of the last warm-up, so its duration can be checked to within one cycle
    always @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            wu_cnt_r <= 16'h0;
        end else if (STOP_MODE && CLK_RUN) begin
            wu_cnt_r <= wu_cnt_r + 16'h1;
        end else begin
            wu_cnt_r <= 16'h0;
        end
    end
    property p_clk_stop; !CLK_RUN |-> STOP_MODE && !CPU_RUN; endproperty
    a_clk_stop: assert property (p_clk_stop)
        else $error("clock gated outside stop");
    property p_mode; $onehot({CPU_RUN, IDLE_MODE, STOP_MODE}); endproperty
    a_mode: assert property (p_mode)
        else $error("modes not exclusive");
    property p_idle_hold;
        IDLE_MODE && !GLOBAL_IRQ_ENABLE && !$past(GLOBAL_IRQ_ENABLE)
            |=> IDLE_MODE;
    endproperty
    a_idle_hold: assert property (p_idle_hold)
        else $error("idle left without global enable");
    property p_req_gie; $rose(|IRQ_REQ) |-> $past(GLOBAL_IRQ_ENABLE); endproperty
    a_req_gie: assert property (p_req_gie)
        else $error("request without global enable");
    property p_ack_clr;
        (EXT_IRQ_PIN2 [*4] ##0 IRQ_ACK[2]) ##1 EXT_IRQ_PIN2 |-> ##1 !IRQ_REQ[2];
    endproperty
    a_ack_clr: assert property (p_ack_clr)
        else $error("pin2 request kept after vectoring");
    property p_warmup;
        $rose(CPU_RUN) && $past(STOP_MODE)
            |-> wu_cnt_r >= WARMUP_CYC && wu_cnt_r <= WARMUP_CYC + 1;
    endproperty
    a_warmup: assert property (p_warmup)
        else $error("warm-up length wrong");
    property p_bhold; S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID; endproperty
    a_bhold: assert property (p_bhold)
        else $error("write response dropped early");
    property p_rhold; S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID; endproperty
    a_rhold: assert property (p_rhold)
        else $error("read response dropped early");
    c_stop: cover property ($rose(STOP_MODE));
    c_idle: cover property ($rose(IDLE_MODE));
    c_ack: cover property (IRQ_ACK[2] && IRQ_REQ[2]);
endmodule // piwc_props

bind piwc_top piwc_props #(.WARMUP_CYC(WARMUP_CYC)) i_props (
    .CORE_CLK(CORE_CLK), .RST(RST), .S_AXI_BVALID(S_AXI_BVALID),
    .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_RVALID(S_AXI_RVALID),
    .S_AXI_RREADY(S_AXI_RREADY), .EXT_IRQ_PIN2(EXT_IRQ_PIN2),
    .GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE), .IRQ_ACK(IRQ_ACK),
    .IRQ_REQ(IRQ_REQ), .CLK_RUN(CLK_RUN), .CPU_RUN(CPU_RUN),
    .IDLE_MODE(IDLE_MODE), .STOP_MODE(STOP_MODE));

// ==== tb/piwc_pin_src.sv ====
// Behavioural model of the external interrupt pin sources
module piwc_pin_src #(
    parameter int PW = 3
) (
    input wire logic clk,
    input wire logic [2:0] hold_low,
    input wire logic [2:0] pulse,
    output logic [2:0] pin
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt [0:2] = '{0, 0, 0};
    // A pulse pulls the pin low for PW cycles and hold_low for as long as it is set; otherwise the pull-up wins
    always @(posedge clk) begin
        for (int i = 0; i < 3; i++) begin
            if (pulse[i]) begin
                cnt[i] <= PW;
            end else if (cnt[i] > 0) begin
                cnt[i] <= cnt[i] - 1;
            end
        end
    end
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            pin[i] = !(hold_low[i] || cnt[i] > 0);
        end
    end
endmodule // piwc_pin_src

// ==== tb/pin_interrupt_wakeup_control_tb.sv ====
// Self-checking bench for the pin interrupt and wake-up controller
module pin_interrupt_wakeup_control_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int WU = 4;
    typedef struct packed {
        logic [7:0] ofs;
        logic [7:0] wd;
        logic [7:0] ev;
        logic [1:0] rs;
    } piwc_row_t;
    piwc_row_t rows [0:4] = '{'{8'h88, 8'h05, 8'h05, 2'h0},
        '{8'ha0, 8'h0f, 8'h0f, 2'h0}, '{8'ha4, 8'ha5, 8'ha5, 2'h0},
        '{8'hac, 8'h0f, 8'h0f, 2'h0}, '{8'h40, 8'h12, 8'h00, 2'h2}};
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic clk_run, cpu_run, idle, stop, gie = 1'b0;
    logic [1:0] bresp, rresp, r;
    logic [7:0] p1 = 8'h00;
    logic [4:0] oreq = '0, oen = '0;
    logic [3:0] ack = '0, req;
    logic [2:0] hold = '0, pulse = '0, pins;
    int bad_count = 0, n_tests = 0, cyc_cnt = 0;

    always #50 clk = ~clk;

    piwc_pin_src i_src (.clk(clk), .hold_low(hold), .pulse(pulse), .pin(pins));
    piwc_top #(.WARMUP_CYC(WU)) i_dut (.CORE_CLK(clk), .RST(rst),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf),
        .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
        .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
        .S_AXI_RREADY(rready), .EXT_IRQ_PIN0(pins[0]),
        .EXT_IRQ_PIN1(pins[1]), .EXT_IRQ_PIN2(pins[2]), .PORT1_PIN(p1),
        .OTHER_IRQ_REQ(oreq), .OTHER_IRQ_EN(oen), .GLOBAL_IRQ_ENABLE(gie),
        .IRQ_ACK(ack), .IRQ_REQ(req), .CLK_RUN(clk_run), .CPU_RUN(cpu_run),
        .IDLE_MODE(idle), .STOP_MODE(stop), .IRQ(irq));

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 8000) begin
            bad_count++;
            tally_and_finish();
        end
    end

    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] o, input logic [7:0] d, output logic [1:0] rs);
        logic ad, wd;
        ad = 1'b0;
        wd = 1'b0;
        awaddr <= {22'h0, o, 2'b00};
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(negedge clk);
            ad = ad | (awvalid & awready);
            wd = wd | (wvalid & wready);
            @(posedge clk);
            if (ad) awvalid <= 1'b0;
            if (wd) wvalid <= 1'b0;
        end while (!(ad && wd));
        do @(negedge clk); while (!bvalid);
        rs = bresp;
        @(posedge clk);
        bready <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wrn(input logic [7:0] o, input logic [7:0] d);
        logic [1:0] rs;
        wr(o, d, rs);
    endtask

    task automatic rchk(input logic [7:0] o, input logic [7:0] e, input string n);
        araddr <= {22'h0, o, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(negedge clk); while (!arready);
        @(posedge clk);
        arvalid <= 1'b0;
        do @(negedge clk); while (!rvalid);
        chk(n, rdata, {24'h0, e});
        @(posedge clk);
        rready <= 1'b0;
        @(posedge clk);
    endtask

    task automatic pls(input logic [2:0] m);
        pulse <= m;
        @(posedge clk);
        pulse <= 3'b000;
        cyc(6);
    endtask

    initial begin
        cyc(10);
        rst <= 1'b0;
        rchk(8'h88, 8'h00, "tpc_rst");
        rchk(8'h87, 8'h00, "pwr_rst");
        chk("run_rst", {cpu_run, clk_run}, 2'b11);
        $display("test reset done");
        foreach (rows[i]) begin
            wr(rows[i].ofs, rows[i].wd, r);
            chk("resp", r, rows[i].rs);
            rchk(rows[i].ofs, rows[i].ev, "row");
            chk("rresp", rresp, rows[i].rs);
        end
        $display("test table done");
        wrn(8'ha0, 8'h00);
        p1 <= 8'h01;
        pls(3'b111);
        rchk(8'h88, 8'h0f, "edge_flags");
        rchk(8'h95, 8'h06, "ifr_flags");
        chk("irq_on", irq, 1'b1);
        wrn(8'h95, 8'hfb);
        rchk(8'h95, 8'h02, "ifr_clr2");
        wrn(8'h95, 8'h00);
        hold[2] <= 1'b1;
        cyc(6);
        wrn(8'h95, 8'h00);
        hold[2] <= 1'b0;
        cyc(6);
        rchk(8'h95, 8'h00, "pin2_rise");
        wrn(8'h88, 8'h05);
        wrn(8'ha8, 8'hff);
        chk("irq_clr", irq, 1'b0);
        wrn(8'hac, 8'h00);
        pls(3'b010);
        chk("irq_mask", irq, 1'b0);
        wrn(8'h88, 8'h05);
        wrn(8'ha8, 8'hff);
        $display("test flags done");
        gie <= 1'b1;
        wrn(8'ha0, 8'h04);
        pls(3'b100);
        chk("req2", req, 4'h4);
        ack <= 4'h4;
        @(posedge clk);
        ack <= 4'h0;
        cyc(3);
        chk("req2_ack", req, 4'h0);
        rchk(8'h95, 8'h00, "flag2_ack");
        wrn(8'h88, 8'h04);
        wrn(8'ha0, 8'h01);
        hold[0] <= 1'b1;
        cyc(6);
        chk("lvl_on", req[0], 1'b1);
        hold[0] <= 1'b0;
        cyc(6);
        chk("lvl_off", req[0], 1'b0);
        wrn(8'h88, 8'h05);
        wrn(8'h87, 8'h01);
        pls(3'b001);
        chk("idle_isr", {cpu_run, req}, 5'h11);
        wrn(8'h88, 8'h05);
        gie <= 1'b0;
        wrn(8'ha0, 8'h00);
        $display("test requests done");
        for (int i = 0; i < 5; i++) begin
            oen <= 5'h01 << i;
            wrn(8'h87, 8'h01);
            chk("idle", idle, 1'b1);
            oreq <= 5'h01 << i;
            cyc(4);
            chk("idle_gie", idle, 1'b1);
            gie <= 1'b1;
            cyc(4);
            chk("idle_wake", cpu_run, 1'b1);
            oreq <= 5'h00;
            gie <= 1'b0;
            @(posedge clk);
        end
        $display("test idle done");
        wrn(8'ha0, 8'h01);
        hold[0] <= 1'b1;
        cyc(2);
        wrn(8'h87, 8'h02);
        cyc(3);
        chk("stop_refused", stop, 1'b0);
        hold[0] <= 1'b0;
        cyc(4);
        wrn(8'h88, 8'h05);
        for (int i = 0; i < 3; i++) begin
            wrn(8'ha0, 8'h01 << i);
            wrn(8'h87, 8'h02);
            cyc(2);
            chk("stopped", {stop, clk_run}, 2'b10);
            pls(3'b001 << i);
            cyc(WU + 8);
            chk("woken", {cpu_run, req}, 5'h10);
        end
        rchk(8'h88, 8'h05, "narrow");
        $display("test stop done");
        wrn(8'ha0, 8'h00);
        wrn(8'h95, 8'h00);
        wrn(8'ha4, 8'h08);
        wrn(8'h87, 8'h02);
        p1 <= p1 ^ 8'h04;
        cyc(6);
        chk("p1_off", {stop, clk_run}, 2'b10);
        p1 <= p1 ^ 8'h08;
        cyc(WU + 8);
        chk("p1_wake", cpu_run, 1'b1);
        rchk(8'h95, 8'h02, "p1_latch");
        $display("test port1 done");
        rst <= 1'b1;
        cyc(2);
        rst <= 1'b0;
        rchk(8'h88, 8'h00, "tpc_rst2");
        $display("test rerun reset done");
        tally_and_finish();
    end
endmodule // pin_interrupt_wakeup_control_tb
